// ==== verilog/audio_out_defines.vh ====
// Constants for the audio output buffer DMA and status block.
// Assumes inclusion by bare name from the design files.
`ifndef AUDIO_OUT_DEFINES_VH
`define AUDIO_OUT_DEFINES_VH
// Register indices on the plain register port
`define AO_REG_STATUS    3'h0
`define AO_REG_CONTROL   3'h1
`define AO_REG_FIRST_BUFFER_POINTER     3'h2
`define AO_REG_SECOND_BUFFER_POINTER     3'h3
`define AO_REG_SIZE      3'h4
`define AO_REG_TSTAMP    3'h5
// Status field positions
`define ST_FIRST_CURRENT 0
`define ST_FIRST_DRAINED 1
`define ST_SECOND_DRAINED 2
`define ST_BW_ERROR      3
`define ST_STARVED       4
// Control field positions
`define CT_RESET         31
`define CT_TRANSMIT      0
`define CT_KEEP_AWAKE    1
`define CT_POLARITY      2
`define CT_IE_FIRST      4
`define CT_IE_SECOND     5
`define CT_IE_BW         6
`define CT_IE_STARVED    7
`define CT_ACK_FIRST     8
`define CT_ACK_SECOND    9
`define CT_ACK_BW        10
`define CT_ACK_STARVED   11
// Reset values
`define RST_BASE         32'h00000000
`define RST_SIZE         32'h00000000
`define RST_FIRST_CURRENT 1'b1
// Sample fetch spacing: 64-byte burst of 16 words
`define BURST_WORDS      5'h10
`endif

// ==== verilog/sample_fifo.v ====
// Sample FIFO with parameter width and depth, valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // Extra pointer bit tells full from empty
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  // Storage write
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers; flush drops stale samples from an old buffer
  always @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sample_fifo

// ==== verilog/audio_out_buffer_dma_status.v ====
// Double-buffered sample fetch, status flags, interrupt and timestamp of an audio output unit.
// Assumes a memory read port answering one word per rdata_valid and a converter that pulses sample_request.
`timescale 1ns/1ps
`include "audio_out_defines.vh"

module audio_out_buffer_dma_status #(
  parameter SIZE_W = 32
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        cycle_count_reset,
  input  wire [31:0] cycle_count_load,
  input  wire        powerdown,
  input  wire [2:0]  reg_addr,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         mem_read_request,
  output reg  [31:0] mem_address,
  input  wire        mem_grant,
  input  wire [31:0] mem_rdata,
  input  wire        mem_rdata_valid,
  input  wire        sample_request,
  output reg  [31:0] sample_out,
  output reg         sample_out_valid,
  output reg         polarity,
  output reg         interrupt_request
);
  // Fetch states
  localparam F_IDLE = 3'b001;
  localparam F_REQ  = 3'b010;
  localparam F_DATA = 3'b100;

  reg [2:0]        fetch_state;
  reg [2:0]        next_fetch_state;
  reg              first_buffer_current;
  reg              fetch_first;
  reg              first_buffer_drained_flag;
  reg              second_buffer_drained_flag;
  reg              memory_bandwidth_error_flag;
  reg              starved_flag;
  reg              first_drained_irq_enable;
  reg              second_drained_irq_enable;
  reg              bandwidth_error_irq_enable;
  reg              starved_irq_enable;
  reg              transmit_enable;
  reg              keep_awake_in_powerdown;
  reg [31:0]       first_buffer_pointer;
  reg [31:0]       second_buffer_pointer;
  reg [SIZE_W-1:0] buffer_size;
  reg [SIZE_W-1:0] fetch_count;
  reg [SIZE_W-1:0] send_count;
  reg [4:0]        burst_count;
  reg              fetch_stalled;
  reg [31:0]       cpu_cycle_counter;
  reg [31:0]       last_buffer_timestamp;
  wire             soft_reset;
  wire             unit_reset;
  wire             running;
  wire             ctl_write;
  wire             ack_first;
  wire             ack_second;
  wire             ack_bw;
  wire             ack_starved;
  wire             fifo_in_ready;
  wire [31:0]      fifo_out_data;
  wire             fifo_out_valid;
  wire             take_sample;
  wire             send_last;
  wire             fetch_last;
  wire [SIZE_W+33:0] fetch_byte_offset;
  wire [SIZE_W+31:0] size_wide;

  assign ctl_write   = reg_write && (reg_addr == `AO_REG_CONTROL);
  assign soft_reset  = ctl_write && reg_wdata[`CT_RESET];
  assign unit_reset  = reset || soft_reset;
  // Powerdown freezes fetch and sample output unless keep-awake is set
  assign running     = transmit_enable && (!powerdown || keep_awake_in_powerdown);
  assign ack_first   = ctl_write && reg_wdata[`CT_ACK_FIRST];
  assign ack_second  = ctl_write && reg_wdata[`CT_ACK_SECOND];
  assign ack_bw      = ctl_write && reg_wdata[`CT_ACK_BW];
  assign ack_starved = ctl_write && reg_wdata[`CT_ACK_STARVED];
  // A sample is consumed only while the current buffer holds data
  assign take_sample = running && sample_request && fifo_out_valid &&
                       !(first_buffer_current ? first_buffer_drained_flag : second_buffer_drained_flag);
  assign send_last   = (send_count == buffer_size - 1'b1);
  assign fetch_last  = (fetch_count == buffer_size - 1'b1);
  // Widened before the cut, so any size width keeps exactly its low bits
  assign fetch_byte_offset = {{32{1'b0}}, fetch_count, 2'b00};
  assign size_wide         = {{32{1'b0}}, buffer_size};

  sample_fifo #(
    .WIDTH (32),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk       (clk),
    .reset     (unit_reset),
    .flush     (!transmit_enable),
    .in_data   (mem_rdata),
    .in_valid  (mem_rdata_valid && fetch_state == F_DATA),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (take_sample)
  );

  // Register writes: control, enables and buffer descriptors
  always @(posedge clk) begin
    if (unit_reset) begin
      transmit_enable            <= 1'b0;
      keep_awake_in_powerdown    <= 1'b0;
      polarity                   <= 1'b0;
      first_drained_irq_enable   <= 1'b0;
      second_drained_irq_enable  <= 1'b0;
      bandwidth_error_irq_enable <= 1'b0;
      starved_irq_enable         <= 1'b0;
      first_buffer_pointer       <= `RST_BASE;
      second_buffer_pointer      <= `RST_BASE;
      buffer_size                <= `RST_SIZE;
    end else if (reg_write) begin
      case (reg_addr)
        `AO_REG_CONTROL: begin
          transmit_enable            <= reg_wdata[`CT_TRANSMIT];
          keep_awake_in_powerdown    <= reg_wdata[`CT_KEEP_AWAKE];
          polarity                   <= reg_wdata[`CT_POLARITY];
          first_drained_irq_enable   <= reg_wdata[`CT_IE_FIRST];
          second_drained_irq_enable  <= reg_wdata[`CT_IE_SECOND];
          bandwidth_error_irq_enable <= reg_wdata[`CT_IE_BW];
          starved_irq_enable         <= reg_wdata[`CT_IE_STARVED];
        end
        `AO_REG_FIRST_BUFFER_POINTER: first_buffer_pointer  <= reg_wdata;
        `AO_REG_SECOND_BUFFER_POINTER: second_buffer_pointer <= reg_wdata;
        `AO_REG_SIZE:  buffer_size           <= reg_wdata[SIZE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Drain side: buffer switch, drained flags, errors; the set wins over an acknowledge
  always @(posedge clk) begin
    if (unit_reset) begin
      first_buffer_current        <= `RST_FIRST_CURRENT;
      first_buffer_drained_flag   <= 1'b0;
      second_buffer_drained_flag  <= 1'b0;
      memory_bandwidth_error_flag <= 1'b0;
      starved_flag                <= 1'b0;
      send_count                  <= {SIZE_W{1'b0}};
    end else begin
      if (ack_first) begin
        first_buffer_drained_flag <= 1'b0;
      end
      if (ack_second) begin
        second_buffer_drained_flag <= 1'b0;
      end
      if (ack_bw) begin
        memory_bandwidth_error_flag <= 1'b0;
      end
      if (ack_starved) begin
        starved_flag <= 1'b0;
      end
      if (take_sample) begin
        if (send_last) begin
          send_count           <= {SIZE_W{1'b0}};
          first_buffer_current <= !first_buffer_current;
          if (first_buffer_current) begin
            first_buffer_drained_flag <= 1'b1;
          end else begin
            second_buffer_drained_flag <= 1'b1;
          end
        end else begin
          send_count <= send_count + 1'b1;
        end
      end else if (running && sample_request) begin
        // Sample due but not sent: classify the cause
        if (first_buffer_current ? first_buffer_drained_flag : second_buffer_drained_flag) begin
          starved_flag <= 1'b1;
        end else begin
          memory_bandwidth_error_flag <= 1'b1;
        end
      end
    end
  end

  // Fetch side: 16-word bursts walking the buffer being filled
  always @* begin
    next_fetch_state = fetch_state;
    case (fetch_state)
      F_IDLE: if (running && !fetch_stalled && fifo_in_ready &&
                  !(fetch_first ? first_buffer_drained_flag : second_buffer_drained_flag)) begin
        next_fetch_state = F_REQ;
      end
      F_REQ: if (mem_grant) begin
        next_fetch_state = F_DATA;
      end
      F_DATA: if (mem_rdata_valid && (fetch_last || burst_count == `BURST_WORDS - 1'b1 || !fifo_in_ready)) begin
        next_fetch_state = F_IDLE;
      end
      default: next_fetch_state = F_IDLE;
    endcase
  end

  // Fetch address and count; FIFO back-pressure ends a burst early
  always @(posedge clk) begin
    if (unit_reset || !transmit_enable) begin
      // The flush loses fetched words, so a disable restarts fetching where the output stands
      fetch_state      <= F_IDLE;
      fetch_first      <= unit_reset ? 1'b1 : first_buffer_current;
      fetch_count      <= unit_reset ? {SIZE_W{1'b0}} : send_count;
      burst_count      <= 5'h00;
      fetch_stalled    <= 1'b0;
      mem_read_request <= 1'b0;
      mem_address      <= 32'h00000000;
    end else begin
      fetch_state      <= next_fetch_state;
      mem_read_request <= (next_fetch_state == F_REQ);
      fetch_stalled    <= 1'b0;
      mem_address      <= (fetch_first ? first_buffer_pointer : second_buffer_pointer) + fetch_byte_offset[31:0];
      if (fetch_state != F_DATA) begin
        burst_count <= 5'h00;
      end else if (mem_rdata_valid && fifo_in_ready) begin
        // A word refused by a full FIFO is not counted and is fetched again
        burst_count <= burst_count + 1'b1;
        if (fetch_last) begin
          fetch_count   <= {SIZE_W{1'b0}};
          fetch_first   <= !fetch_first;
          fetch_stalled <= 1'b1;
        end else begin
          fetch_count <= fetch_count + 1'b1;
        end
      end
    end
  end

  // Output holding register repeats its last value on error
  always @(posedge clk) begin
    if (unit_reset) begin
      sample_out       <= 32'h00000000;
      sample_out_valid <= 1'b0;
    end else begin
      sample_out_valid <= running && sample_request;
      if (take_sample) begin
        sample_out <= fifo_out_data;
      end
    end
  end

  // Cycle counter is not touched by the soft reset
  always @(posedge clk) begin
    if (reset || cycle_count_reset) begin
      cpu_cycle_counter <= cycle_count_load;
    end else begin
      cpu_cycle_counter <= cpu_cycle_counter + 32'h00000001;
    end
  end

  // Timestamp of last sample of a finished buffer
  always @(posedge clk) begin
    if (unit_reset) begin
      last_buffer_timestamp <= 32'h00000000;
    end else if (take_sample && send_last) begin
      last_buffer_timestamp <= cpu_cycle_counter;
    end
  end

  // Level interrupt; acknowledge removes it one edge later
  always @(posedge clk) begin
    if (unit_reset) begin
      interrupt_request <= 1'b0;
    end else begin
      interrupt_request <= (starved_flag && starved_irq_enable) ||
                           (memory_bandwidth_error_flag && bandwidth_error_irq_enable) ||
                           (first_buffer_drained_flag && first_drained_irq_enable) ||
                           (second_buffer_drained_flag && second_drained_irq_enable);
    end
  end

  // Read data, registered; acknowledge bits read 0
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        `AO_REG_STATUS: reg_rdata <= {27'h0000000, starved_flag, memory_bandwidth_error_flag,
                                      second_buffer_drained_flag, first_buffer_drained_flag,
                                      first_buffer_current};
        `AO_REG_CONTROL: reg_rdata <= {24'h000000, starved_irq_enable, bandwidth_error_irq_enable,
                                       second_drained_irq_enable, first_drained_irq_enable, 1'b0,
                                       polarity, keep_awake_in_powerdown, transmit_enable};
        `AO_REG_FIRST_BUFFER_POINTER:  reg_rdata <= first_buffer_pointer;
        `AO_REG_SECOND_BUFFER_POINTER:  reg_rdata <= second_buffer_pointer;
        `AO_REG_SIZE:   reg_rdata <= size_wide[31:0];
        `AO_REG_TSTAMP: reg_rdata <= last_buffer_timestamp;
        default:        reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule // audio_out_buffer_dma_status

// ==== bench/audio_mem_model.sv ====
// Local memory stand-in: grants a burst after a set delay, then 16 words.
// Assumes word data equals its byte address, so samples are predictable.
`timescale 1ns/1ps
module audio_mem_model (
  input  wire        clk,
  input  wire        reset,
  input  wire        mem_read_request,
  input  wire [31:0] mem_address,
  input  wire [31:0] stall,
  output reg         mem_grant,
  output reg  [31:0] mem_rdata,
  output reg         mem_rdata_valid
);
  reg     [31:0] a;
  integer        i;
  // One burst at a time; a released data line shows its last word inverted
  initial begin
    mem_grant = 1'b0;
    mem_rdata = 32'h00000000;
    mem_rdata_valid = 1'b0;
    forever begin
      @(posedge clk);
      if (mem_read_request && !reset) begin
        repeat (stall) @(posedge clk);
        a = mem_address;
        mem_grant <= 1'b1;
        @(posedge clk);
        mem_grant <= 1'b0;
        for (i = 0; i < 16; i = i + 1) begin
          mem_rdata <= a + 4 * i;
          mem_rdata_valid <= 1'b1;
          @(posedge clk);
        end
        mem_rdata_valid <= 1'b0;
        mem_rdata <= ~(a + 32'h0000003C);
      end
    end
  end
endmodule // audio_mem_model

// ==== bench/audio_out_buffer_dma_status_chk.sv ====
// Port-level checks of the audio output buffer block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "audio_out_defines.vh"
module audio_out_buffer_dma_status_chk (
  input wire        clk,
  input wire        reset,
  input wire [2:0]  reg_addr,
  input wire        reg_write,
  input wire        reg_read,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        mem_read_request,
  input wire        mem_grant,
  input wire        sample_request,
  input wire [31:0] sample_out,
  input wire        sample_out_valid,
  input wire        polarity,
  input wire        interrupt_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Acks, enables and soft reset all arrive through a control write
  wire ctl_wr = reg_write && reg_addr == `AO_REG_CONTROL;
  irq_off_a: assert property (ctl_wr && reg_wdata[7:4] == 4'h0 |-> ##2 !interrupt_request)
    else $error("irq still up with all enables off");
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> !interrupt_request && !mem_read_request)
    else $error("outputs active after reset");
  soft_reset_a: assert property (ctl_wr && reg_wdata[31] |=> !interrupt_request && !polarity && !sample_out_valid)
    else $error("soft reset left outputs active");
  ack_read_zero_a: assert property (reg_read && reg_addr == `AO_REG_CONTROL |=> reg_rdata[11:8] == 4'h0 && !reg_rdata[31])
    else $error("strobe bits read back nonzero");
  valid_cause_a: assert property ($rose(sample_out_valid) |-> $past(sample_request))
    else $error("sample valid without request");
  req_hold_a: assert property (mem_read_request && !mem_grant && !(ctl_wr && reg_wdata[`CT_RESET]) &&
                               !$past(ctl_wr && !reg_wdata[`CT_TRANSMIT]) |=> mem_read_request)
    else $error("memory request dropped before grant");
  irq_sticky_a: assert property (interrupt_request && !ctl_wr && !$past(ctl_wr) |=> interrupt_request)
    else $error("irq fell without control write");
  hold_sample_a: assert property (!$past(sample_request) && !$past(reg_write) |-> $stable(sample_out))
    else $error("sample changed without request");
endmodule // audio_out_buffer_dma_status_chk
bind audio_out_buffer_dma_status audio_out_buffer_dma_status_chk chk_i (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .mem_read_request(mem_read_request), .mem_grant(mem_grant),
  .sample_request(sample_request), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
  .polarity(polarity), .interrupt_request(interrupt_request));

// ==== bench/audio_out_buffer_dma_status_tb.sv ====
// Self-checking bench: registers, double-buffer streaming, starvation, bandwidth error.
// Assumes the memory model returns each word equal to its address.
`timescale 1ns/1ps
`include "audio_out_defines.vh"
module audio_out_buffer_dma_status_tb;
  localparam [31:0] RUN  = 32'h000000B1; // Polarity left 0 throughout
  localparam [31:0] B1   = 32'h00001000;
  localparam [31:0] B2   = 32'h00002000;
  localparam [31:0] LOAD = 32'hFFFFFFF0; // Near wrap, so both counters wrap past zero before the stamp check
  reg         clk, reset, cycle_count_reset, reg_write, reg_read, sample_request, powerdown;
  reg  [2:0]  reg_addr;
  reg  [31:0] reg_wdata, cyc, d, t_last, stall;
  wire [31:0] reg_rdata, mem_address, mem_rdata, sample_out;
  wire        mem_read_request, mem_grant, mem_rdata_valid, sample_out_valid, polarity, interrupt_request;
  integer     n_errors, check_count, i;
  audio_out_buffer_dma_status audio_out_buffer_dma_status_i (.clk(clk), .reset(reset),
    .cycle_count_reset(cycle_count_reset), .cycle_count_load(LOAD), .powerdown(powerdown),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mem_read_request(mem_read_request), .mem_address(mem_address),
    .mem_grant(mem_grant), .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid),
    .sample_request(sample_request), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
    .polarity(polarity), .interrupt_request(interrupt_request));
  audio_mem_model audio_mem_model_i (.clk(clk), .reset(reset), .mem_read_request(mem_read_request),
    .mem_address(mem_address), .stall(stall), .mem_grant(mem_grant), .mem_rdata(mem_rdata),
    .mem_rdata_valid(mem_rdata_valid));
  // Reference cycle count, loaded the same way as the design's copy
  always @(posedge clk) cyc <= cycle_count_reset ? LOAD : cyc + 32'h00000001;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] a, input [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rd(input [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Status read, compared under a mask so unsettled bits stay out
  task st(input [31:0] m, input [31:0] e);
    rd(`AO_REG_STATUS);
    chk(d & m, e);
  endtask
  // One converter request; the held sample must come back valid
  task smp(input [31:0] e);
    integer n;
    @(posedge clk);
    sample_request <= 1'b1;
    @(posedge clk);
    sample_request <= 1'b0;
    #1 t_last = cyc;
    n = 0;
    while (sample_out_valid !== 1'b1 && n < 3) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    chk({31'h0, sample_out_valid}, 32'h1);
    chk(sample_out, e);
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    st(32'hFFFFFFFF, 32'h1);
    rd(`AO_REG_CONTROL);
    chk(d, 32'h0);
    rd(`AO_REG_SIZE);
    chk(d, 32'h0);
    $display("reset values done");
  endtask
  task t_regs;
    wr(`AO_REG_CONTROL, 32'h00000004);
    #1 chk({31'h0, polarity}, 32'h1);
    wr(`AO_REG_CONTROL, 32'h00000F00);
    rd(`AO_REG_CONTROL);
    chk(d, 32'h0);
    wr(`AO_REG_FIRST_BUFFER_POINTER, B1);
    wr(`AO_REG_SECOND_BUFFER_POINTER, B2);
    wr(`AO_REG_SIZE, 32'h10);
    rd(`AO_REG_SECOND_BUFFER_POINTER);
    chk(d, B2);
    rd(3'h7);
    chk(d, 32'h0);
    $display("register access done");
  endtask
  task t_stream;
    wr(`AO_REG_CONTROL, RUN);
    repeat (60) @(posedge clk);
    for (i = 0; i < 16; i = i + 1) smp(B1 + 4 * i);
    rd(`AO_REG_TSTAMP);
    chk({31'h0, (d - t_last + 32'h3) <= 32'h6}, 32'h1);
    st(32'h1F, 32'h2);
    chk({31'h0, interrupt_request}, 32'h1);
    wr(`AO_REG_CONTROL, RUN | 32'h100);
    @(posedge clk);
    #1 chk({31'h0, interrupt_request}, 32'h0);
    st(32'h1F, 32'h0);
    for (i = 0; i < 16; i = i + 1) smp(B2 + 4 * i);
    st(32'h1F, 32'h5);
    for (i = 0; i < 16; i = i + 1) smp(B1 + 4 * i);
    st(32'h0F, 32'h6);
    smp(B1 + 32'h3C);
    st(32'h10, 32'h10);
    wr(`AO_REG_CONTROL, RUN | 32'h200);
    st(32'h14, 32'h10);
    chk({31'h0, interrupt_request}, 32'h1);
    wr(`AO_REG_CONTROL, RUN | 32'h800);
    st(32'h10, 32'h0);
    wr(`AO_REG_CONTROL, 32'h0);
    repeat (40) @(posedge clk);
    $display("streaming and starvation done");
  endtask
  task t_bw;
    stall = 32'd150;
    wr(`AO_REG_CONTROL, 32'h80000000);
    st(32'h1F, 32'h1);
    rd(`AO_REG_FIRST_BUFFER_POINTER);
    chk(d, 32'h0);
    wr(`AO_REG_FIRST_BUFFER_POINTER, B1);
    wr(`AO_REG_SECOND_BUFFER_POINTER, B2);
    wr(`AO_REG_SIZE, 32'h10);
    wr(`AO_REG_CONTROL, 32'hF1);
    repeat (5) @(posedge clk);
    smp(32'h0);
    st(32'h18, 32'h08);
    chk({31'h0, interrupt_request}, 32'h1);
    repeat (250) @(posedge clk);
    st(32'h18, 32'h08);
    chk({31'h0, interrupt_request}, 32'h1);
    smp(B1);
    wr(`AO_REG_CONTROL, 32'h000004F1);
    st(32'h18, 32'h0);
    stall = 32'd0;
    // Powerdown without keep-awake: a request is ignored and raises no flag
    @(posedge clk);
    powerdown <= 1'b1;
    @(posedge clk);
    sample_request <= 1'b1;
    @(posedge clk);
    sample_request <= 1'b0;
    #1 chk({31'h0, sample_out_valid}, 32'h0);
    st(32'h18, 32'h0);
    wr(`AO_REG_CONTROL, 32'h000000F3);
    smp(B1 + 32'h4);
    powerdown <= 1'b0;
    $display("bandwidth error done");
  endtask
  // Single exit for both the normal end and the watchdog
  task wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    reset = 1'b1;
    cycle_count_reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    sample_request = 1'b0;
    powerdown = 1'b0;
    stall = 32'd0;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    cycle_count_reset <= 1'b0;
    t_reset;
    t_regs;
    t_stream;
    t_bw;
    wrap_up;
  end
endmodule // audio_out_buffer_dma_status_tb
